//--- verilog/csw_port.sv
// Two-wire target that gives word access to command-code addressed registers.
// Assumes open-drain lines resolved outside; results come in from the sensing logic.
`timescale 1ns/1ps
`default_nettype none
module csw_port #(
  parameter int NUM_REGS = csw_pkg::REG_COUNT
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Bus lines
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Results from the sensing chain
  input wire logic [csw_pkg::WORD_W-1:0] clear_result,
  input wire logic [csw_pkg::WORD_W-1:0] red_result,
  input wire logic [csw_pkg::WORD_W-1:0] green_result,
  input wire logic [csw_pkg::WORD_W-1:0] blue_result,
  input wire logic [csw_pkg::WORD_W-1:0] ir_result,
  // Settings word and its write pulse
  output logic [csw_pkg::WORD_W-1:0] config_word,
  output logic config_written
);
  import csw_pkg::*;

  // Register count must cover every decoded command code
  if (NUM_REGS < 13 || NUM_REGS > 256) begin : g_bad_regs
    $error("NUM_REGS out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line events
  logic scl_rise, scl_fall, sda_level, start_seen, stop_seen;

  csw_sync u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .sda_level(sda_level),
    .start_seen(start_seen),
    .stop_seen(stop_seen)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register read mux
  function automatic logic [WORD_W-1:0] read_word(input logic [CMD_W-1:0] cmd, input logic [WORD_W-1:0] cfg,
      input logic [WORD_W-1:0] c, input logic [WORD_W-1:0] r, input logic [WORD_W-1:0] g,
      input logic [WORD_W-1:0] b, input logic [WORD_W-1:0] ir);
    case (cmd)
      CMD_CONFIG: read_word = cfg;
      CMD_CLEAR: read_word = c;
      CMD_RED: read_word = r;
      CMD_GREEN: read_word = g;
      CMD_BLUE: read_word = b;
      CMD_IR: read_word = ir;
      CMD_ID: read_word = ID_VALUE;
      default: read_word = 16'h0000;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Protocol state
  csw_state_t state, next_state;
  logic [7:0] shift, next_shift;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic rd_mode, next_rd_mode;
  logic [1:0] byte_idx, next_byte_idx;
  logic [CMD_W-1:0] cmd, next_cmd;
  logic [7:0] low_byte, next_low_byte;
  logic [WORD_W-1:0] rd_word, next_rd_word;
  logic [WORD_W-1:0] cfg, next_cfg;
  logic cfg_pulse, next_cfg_pulse;
  logic drive_low, next_drive_low;
  logic nacked, next_nacked;
  logic byte_done, next_byte_done;

  always_comb begin
    next_state = state;
    next_shift = shift;
    next_bit_cnt = bit_cnt;
    next_rd_mode = rd_mode;
    next_byte_idx = byte_idx;
    next_cmd = cmd;
    next_low_byte = low_byte;
    next_rd_word = rd_word;
    next_cfg = cfg;
    next_cfg_pulse = 1'b0;
    next_drive_low = drive_low;
    next_nacked = nacked;
    next_byte_done = byte_done;
    if (start_seen) begin
      next_state = CSW_ADDR;
      next_bit_cnt = 3'h0;
      next_drive_low = 1'b0;
      next_byte_done = 1'b0;
    end else if (stop_seen) begin
      next_state = CSW_IDLE;
      next_drive_low = 1'b0;
    end else begin
      case (state)
        CSW_IDLE: begin
          next_drive_low = 1'b0;
        end
        CSW_ADDR: begin
          if (scl_rise) begin
            next_shift = {shift[6:0], sda_level};
            next_bit_cnt = bit_cnt + 3'h1;
            next_byte_done = (bit_cnt == 3'(BIT_LAST));
          end
          // Decide only after eight bits, never on the fall that closes the start
          if (scl_fall && byte_done) begin
            next_byte_done = 1'b0;
            if (shift[7:1] == TARGET_ADDR) begin
              next_rd_mode = shift[0];
              next_drive_low = 1'b1;
              next_state = CSW_AACK;
              next_byte_idx = 2'h0;
            end else begin
              next_state = CSW_SKIP;
            end
          end
        end
        CSW_AACK: begin
          if (scl_fall) begin
            next_drive_low = 1'b0;
            next_bit_cnt = 3'h0;
            if (rd_mode) begin
              next_state = CSW_RBYTE;
              next_shift = rd_word[7:0];
              next_drive_low = ~rd_word[7];
            end else begin
              next_state = CSW_WBYTE;
            end
          end
        end
        CSW_WBYTE: begin
          if (scl_rise) begin
            next_shift = {shift[6:0], sda_level};
            next_bit_cnt = bit_cnt + 3'h1;
          end
          if (scl_fall && bit_cnt == 3'h0) begin
            next_drive_low = 1'b1;
            next_state = CSW_WACK;
            case (byte_idx)
              2'h0: begin
                next_cmd = shift;
                next_rd_word = read_word(shift, cfg, clear_result, red_result, green_result, blue_result,
                  ir_result);
              end
              2'h1: next_low_byte = shift;
              default: begin
                if (cmd == CMD_CONFIG) begin
                  next_cfg = {shift, low_byte};
                  next_cfg_pulse = 1'b1;
                end
              end
            endcase
          end
        end
        CSW_WACK: begin
          if (scl_fall) begin
            next_drive_low = 1'b0;
            next_bit_cnt = 3'h0;
            next_byte_idx = (byte_idx == 2'h2) ? 2'h2 : byte_idx + 2'h1;
            next_state = CSW_WBYTE;
          end
        end
        CSW_RBYTE: begin
          if (scl_fall) begin
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == 3'(BIT_LAST)) begin
              next_drive_low = 1'b0;
              next_state = CSW_RACK;
            end else begin
              next_shift = {shift[6:0], 1'b0};
              next_drive_low = ~shift[6];
            end
          end
        end
        CSW_RACK: begin
          if (scl_rise) begin
            next_nacked = sda_level;
          end
          if (scl_fall) begin
            next_bit_cnt = 3'h0;
            if (nacked || byte_idx != 2'h0) begin
              next_state = CSW_SKIP;
              next_drive_low = 1'b0;
            end else begin
              next_byte_idx = 2'h1;
              next_shift = rd_word[15:8];
              next_drive_low = ~rd_word[15];
              next_state = CSW_RBYTE;
            end
          end
        end
        default: begin
          next_drive_low = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= CSW_IDLE;
      shift <= 8'h00;
      bit_cnt <= 3'h0;
      rd_mode <= 1'b0;
      byte_idx <= 2'h0;
      cmd <= 8'h00;
      low_byte <= 8'h00;
      rd_word <= 16'h0000;
      cfg <= CONFIG_RESET;
      cfg_pulse <= 1'b0;
      drive_low <= 1'b0;
      nacked <= 1'b0;
      byte_done <= 1'b0;
    end else begin
      state <= next_state;
      shift <= next_shift;
      bit_cnt <= next_bit_cnt;
      rd_mode <= next_rd_mode;
      byte_idx <= next_byte_idx;
      cmd <= next_cmd;
      low_byte <= next_low_byte;
      rd_word <= next_rd_word;
      cfg <= next_cfg;
      cfg_pulse <= next_cfg_pulse;
      drive_low <= next_drive_low;
      nacked <= next_nacked;
      byte_done <= next_byte_done;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = drive_low;
  assign config_word = cfg;
  assign config_written = cfg_pulse;
endmodule
`default_nettype wire

//--- common/csw_pkg.sv
// Constants and types for the colour sensor two-wire word port.
// Assumes a single 10 MHz clock and a synchronous active-high reset.
//
// Summary of operation
// - The port answers only when the 7-bit address after a start equals its fixed target address.
// - A word write is start, address with write bit, command code, low byte, high byte, stop, each byte acknowledged.
// - The port drives only the acknowledge bits and read data; the host drives everything else.
// - Every setting and result is reached only through command-code addressed registers on the bus.
// - Each colour and infrared result is a 16-bit value sent low byte then high byte in one word read.
package csw_pkg;
  localparam logic [6:0] TARGET_ADDR = 7'h10;
  localparam int REG_COUNT = 16;
  localparam int CMD_W = 8;
  localparam int WORD_W = 16;
  localparam logic [7:0] CMD_CONFIG = 8'h00;
  localparam logic [7:0] CMD_CLEAR = 8'h04;
  localparam logic [7:0] CMD_RED = 8'h05;
  localparam logic [7:0] CMD_GREEN = 8'h06;
  localparam logic [7:0] CMD_BLUE = 8'h07;
  localparam logic [7:0] CMD_IR = 8'h08;
  localparam logic [7:0] CMD_ID = 8'h0c;
  localparam logic [15:0] CONFIG_RESET = 16'h8001;
  // Identity value is arbitrary
  localparam logic [15:0] ID_VALUE = 16'h005a;
  localparam int BIT_LAST = 7;

  typedef enum logic [2:0] {
    CSW_IDLE = 3'b000,
    CSW_ADDR = 3'b001,
    CSW_AACK = 3'b011,
    CSW_WBYTE = 3'b010,
    CSW_WACK = 3'b110,
    CSW_RBYTE = 3'b111,
    CSW_RACK = 3'b101,
    CSW_SKIP = 3'b100
  } csw_state_t;
endpackage

//--- verilog/csw_sync.sv
// Two-flop synchroniser with edge and condition detection for the bus lines.
// Assumes scl and sda arrive asynchronously from pins.
`timescale 1ns/1ps
`default_nettype none
module csw_sync (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Raw lines
  input wire logic scl_in,
  input wire logic sda_in,
  // Synchronised events
  output logic scl_rise,
  output logic scl_fall,
  output logic sda_level,
  output logic start_seen,
  output logic stop_seen
);
  logic [1:0] scl_meta, sda_meta;
  logic scl_q, sda_q;
  logic [1:0] next_scl_meta, next_sda_meta;
  logic next_scl_q, next_sda_q;

  always_comb begin
    next_scl_meta = {scl_meta[0], scl_in};
    next_sda_meta = {sda_meta[0], sda_in};
    next_scl_q = scl_meta[1];
    next_sda_q = sda_meta[1];
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      scl_meta <= 2'h3;
      sda_meta <= 2'h3;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_meta <= next_scl_meta;
      sda_meta <= next_sda_meta;
      scl_q <= next_scl_q;
      sda_q <= next_sda_q;
    end
  end

  assign scl_rise = scl_meta[1] & ~scl_q;
  assign scl_fall = ~scl_meta[1] & scl_q;
  assign sda_level = sda_meta[1];
  assign start_seen = scl_meta[1] & scl_q & sda_q & ~sda_meta[1];
  assign stop_seen = scl_meta[1] & scl_q & ~sda_q & sda_meta[1];
endmodule
`default_nettype wire

//--- verif/csw_host_model.sv
// Two-wire host model: drives the clock and pulls the data line.
// Assumes the bench resolves the data line with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module csw_host_model #(
  parameter int HALF = 6
) (
  // Clock
  input wire logic ref_clk,
  // Bus lines
  output logic scl,
  output logic sda_pull,
  input wire logic sda_line
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // One bit, data set while clock low, sampled mid high
  task automatic bit_io(input logic b, output logic r);
    sda_pull <= ~b;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF / 2);
    r = sda_line;
    tick(HALF - HALF / 2);
    scl <= 1'b0;
    tick(1);
  endtask
  // Start or repeated start
  task automatic start_cond();
    sda_pull <= 1'b0;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF);
    sda_pull <= 1'b1;
    tick(HALF);
    scl <= 1'b0;
    tick(1);
  endtask
  task automatic stop_cond();
    sda_pull <= 1'b1;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF);
    sda_pull <= 1'b0;
    tick(HALF);
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(nack, r);
  endtask
endmodule
`default_nettype wire

//--- verif/csw_port_sva.sv
// Checker for the word port pins and settings outputs.
// Bound to every port instance; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module csw_port_chk #(
  parameter int NUM_REGS = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Bus lines
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Settings
  input wire logic [csw_pkg::WORD_W-1:0] config_word,
  input wire logic config_written
);
  import csw_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_reset_state;
    @(posedge ref_clk) disable iff (1'b0) rst |=> !sda_oe && !config_written && config_word == CONFIG_RESET;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong");
  property p_open_drain;
    sda_out == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("data driven high");
  property p_pull_low;
    sda_oe |-> !sda_in;
  endproperty
  a_pull_low: assert property (p_pull_low) else $error("line not low while driven");
  property p_oe_scl_low;
    (sda_oe != $past(sda_oe)) |-> !scl_in;
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("data moved with clock high");
  property p_one_pulse;
    config_written |=> !config_written;
  endproperty
  a_one_pulse: assert property (p_one_pulse) else $error("write pulse too long");
  property p_cfg_pulse;
    $changed(config_word) |-> ##[0:1] config_written;
  endproperty
  a_cfg_pulse: assert property (p_cfg_pulse) else $error("settings changed without write");
  property p_oe_release;
    $rose(sda_oe) |-> ##[1:130] !sda_oe;
  endproperty
  a_oe_release: assert property (p_oe_release) else $error("data line held too long");
  c_write: cover property (config_written);
  c_ack: cover property ($rose(sda_oe));
  c_start: cover property (scl_in && $fell(sda_in));
endmodule
bind csw_port csw_port_chk #(.NUM_REGS(NUM_REGS)) chk_u (.ref_clk(ref_clk), .rst(rst), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .config_word(config_word), .config_written(config_written));
`default_nettype wire

//--- verif/tb.sv
// Bench for the word port: host model, result words and checks.
// Assumes the host model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_fail++; $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
  import csw_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic scl, sda_pull, sda_line, sda_out, sda_oe, config_written;
  logic [WORD_W-1:0] res [5];
  logic [WORD_W-1:0] config_word;
  int n_fail = 0;
  int cmp_count = 0;
  int n_pulse = 0;
  int cyc = 0;
  always #50 ref_clk = ~ref_clk;
  assign sda_line = ~(sda_pull | (sda_oe & ~sda_out));
  csw_host_model #(.HALF(6)) host_u (.ref_clk(ref_clk), .scl(scl), .sda_pull(sda_pull), .sda_line(sda_line));
  csw_port #(.NUM_REGS(REG_COUNT)) dut_u (.ref_clk(ref_clk), .rst(rst), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .clear_result(res[0]), .red_result(res[1]), .green_result(res[2]),
    .blue_result(res[3]), .ir_result(res[4]), .config_word(config_word), .config_written(config_written));
  always @(posedge ref_clk) if (config_written === 1'b1) n_pulse++;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic write_word(input logic [6:0] addr, input logic [7:0] cmd, input logic [15:0] w, input logic ok);
    logic a;
    logic [23:0] by;
    by = {w, cmd};
    host_u.start_cond();
    host_u.wbyte({addr, 1'b0}, a);
    `CHK(a, ok)
    for (int i = 0; i < 3 && ok; i++) begin
      host_u.wbyte(by[i*8+:8], a);
      `CHK(a, 1'b1)
    end
    host_u.stop_cond();
  endtask
  task automatic read_word(input logic [7:0] cmd, output logic [15:0] w);
    logic a;
    host_u.start_cond();
    host_u.wbyte({TARGET_ADDR, 1'b0}, a);
    `CHK(a, 1'b1)
    host_u.wbyte(cmd, a);
    `CHK(a, 1'b1)
    host_u.start_cond();
    host_u.wbyte({TARGET_ADDR, 1'b1}, a);
    `CHK(a, 1'b1)
    host_u.rbyte(1'b0, w[7:0]);
    host_u.rbyte(1'b1, w[15:8]);
    host_u.stop_cond();
  endtask
  task automatic t_config_write();
    int p;
    p = n_pulse;
    write_word(TARGET_ADDR, CMD_CONFIG, 16'h1234, 1'b1);
    `CHK(n_pulse, p + 1)
    `CHK(config_word, 16'h1234)
  endtask
  task automatic t_refused();
    int p;
    p = n_pulse;
    write_word(7'h11, CMD_CONFIG, 16'h5555, 1'b0);
    write_word(TARGET_ADDR, CMD_RED, 16'hbeef, 1'b1);
    `CHK(n_pulse, p)
    `CHK(config_word, 16'h1234)
  endtask
  task automatic t_read_all();
    logic [7:0] cmds [8];
    logic [15:0] exp [8];
    logic [15:0] w;
    for (int k = 0; k < 5; k++) res[k] <= 16'h0f1e + 16'h2211 * k[15:0];
    @(posedge ref_clk);
    cmds = '{CMD_CONFIG, CMD_CLEAR, CMD_RED, CMD_GREEN, CMD_BLUE, CMD_IR, CMD_ID, 8'h01};
    exp = '{16'h1234, res[0], res[1], res[2], res[3], res[4], ID_VALUE, 16'h0000};
    for (int k = 0; k < 8; k++) begin
      read_word(cmds[k], w);
      `CHK(w, exp[k])
    end
  endtask
  initial begin
    foreach (res[k]) res[k] = '0;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    `CHK(config_word, CONFIG_RESET)
    `CHK(sda_oe, 1'b0)
    t_config_write();
    t_refused();
    t_read_all();
    print_verdict();
  end
endmodule
`default_nettype wire
